//--- design/chmap_defs.svh
// Offsets, field positions, reset values and codes of the channel map bank
`ifndef CHMAP_DEFS_SVH
`define CHMAP_DEFS_SVH

// Register indexes; byte address is four times the index
`define IDX_FIRST_MAP   8'h11
`define IDX_SECOND_MAP  8'h12
`define IDX_SEQ_STATUS  8'h13

// Channel map fields
`define MAP_EN_BIT      15
`define MAP_RSV_BIT     14
`define MAP_SETUP_HI    13
`define MAP_SETUP_LO    12
`define MAP_RSV_HI      11
`define MAP_RSV_LO      10
`define MAP_POS_HI      9
`define MAP_POS_LO      5
`define MAP_NEG_HI      4
`define MAP_NEG_LO      0

// Reset value and writable bits
`define MAP_RESET       16'h0001
`define MAP_WMASK       16'hB3FF

// Input select codes
`define AIN_LAST_CODE   5'h04
`define REF_POS_CODE    5'h15
`define REF_NEG_CODE    5'h16

// Sequencer status fields
`define STS_RUN_BIT     0
`define STS_CH_BIT      1
`define STS_OK_BIT      2
`define STS_SETUP_LO    4

`endif

//--- design/chmap_pkg.sv
// Types shared by the channel map bank
`default_nettype none
package chmap_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_RUN  = 2'b10
  } seq_state_t;

  typedef logic [15:0] map_word_t;
endpackage : chmap_pkg
`default_nettype wire

//--- design/chmap_word.sv
// One channel map register with reserved bits held at zero
`include "chmap_defs.svh"
`default_nettype none
module chmap_word #(
  parameter logic [15:0] RESET_VAL = `MAP_RESET
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              wr_lo,
  input  wire logic              wr_hi,
  input  wire logic [15:0]       wr_data,
  output chmap_pkg::map_word_t   q
);
  chmap_pkg::map_word_t word_r;
  chmap_pkg::map_word_t word_nxt;
  logic [15:0]          lane_mask;

  always_comb begin
    lane_mask = {{8{wr_hi}}, {8{wr_lo}}} & `MAP_WMASK;
    // Reserved bits never store a one, whatever software writes
    word_nxt  = (word_r & ~lane_mask) | (wr_data & lane_mask); // R3 R6 R11
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_r <= RESET_VAL; // R2
    end else begin
      word_r <= word_nxt;
    end
  end

  assign q = word_r;
endmodule : chmap_word
`default_nettype wire

//--- design/chan_sequencer.sv
// Steps through the enabled channels, one per finished conversion
`default_nettype none
module chan_sequencer #(
  parameter int NCH = 2,
  parameter int CW  = (NCH > 1) ? $clog2(NCH) : 1
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [NCH-1:0]       enable,
  input  wire logic                 conv_done,
  output chmap_pkg::seq_state_t     state,
  output logic [CW-1:0]             cur_ch
);
  chmap_pkg::seq_state_t state_r;
  chmap_pkg::seq_state_t state_nxt;
  logic [CW-1:0]         ch_r;
  logic [CW-1:0]         ch_nxt;
  logic [CW-1:0]         after_cur;

  // First enabled channel after 'from', wrapping; 'from' itself comes last
  function automatic logic [CW-1:0] next_enabled(input logic [NCH-1:0] en,
                                                 input logic [CW-1:0]  from);
    int idx;
    logic [CW-1:0] pick;
    pick = from;
    for (int k = NCH; k >= 1; k--) begin
      idx = (int'(from) + k) % NCH;
      if (en[idx]) begin
        pick = CW'(idx);
      end
    end
    return pick;
  endfunction : next_enabled

  always_comb begin
    state_nxt = state_r;
    ch_nxt    = ch_r;
    after_cur = next_enabled(enable, ch_r);
    case (state_r)
      chmap_pkg::SEQ_IDLE: begin
        if (|enable) begin
          state_nxt = chmap_pkg::SEQ_RUN;
          ch_nxt    = next_enabled(enable, CW'(NCH - 1));
        end
      end
      chmap_pkg::SEQ_RUN: begin
        if (!(|enable)) begin
          state_nxt = chmap_pkg::SEQ_IDLE;
        end else if (conv_done || !enable[ch_r]) begin
          // Moves on by itself; a lone channel just stays put
          ch_nxt = after_cur; // R5
        end
      end
      default: begin
        state_nxt = chmap_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= chmap_pkg::SEQ_IDLE;
      ch_r    <= '0;
    end else begin
      state_r <= state_nxt;
      ch_r    <= ch_nxt;
    end
  end

  assign state  = state_r;
  assign cur_ch = ch_r;
endmodule : chan_sequencer
`default_nettype wire

//--- design/chmap_bank.sv
// Channel map register bank with APB slave and channel sequencer
// Function
// R1 - Channel 1 negative select: codes 0-4 AIN0-4, 10101 REF+, 10110 REF-; resets AIN1.
// R2 - Channel 2 map register sits at index 0x12, resets to 0x0001.
// R3 - Each map register is 16 bits: enable, inputs and setup choice.
// R4 - Bit 15 enables channel 2 when one; resets to zero.
// R5 - With several channels enabled, the converter cycles through them unaided.
// R6 - Bit 14 is reserved, reads zero; software writes zero there.
// R7 - Bits 13:12 pick setup 0 to 3; reset to zero.
// R8 - The chosen setup applies its four registers together to the channel.
// R9 - Software writes one setup code everywhere to share a single setup.
// R10 - Bits 9:5 select positive input with the same codes; reset AIN0.
// R11 - Bits 11:10 are reserved, read zero; software writes zero.
// R12 - Undefined input codes are reserved; routing for them is undefined.
`include "chmap_defs.svh"
`default_nettype none
module chmap_bank #(
  parameter int NCH = 2,
  parameter int AW  = 8
) (
  input  wire logic          CLK,
  input  wire logic          RST,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [AW-1:0] PADDR,
  input  wire logic [31:0]   PWDATA,
  input  wire logic [3:0]    PSTRB,
  output logic [31:0]        PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  input  wire logic          CONV_DONE,
  output logic               CH_ACTIVE,
  output logic               CH_INDEX,
  output logic [4:0]         AIN_POS_SEL,
  output logic [4:0]         AIN_NEG_SEL,
  output logic [1:0]         SETUP_SEL,
  output logic [3:0]         SETUP_APPLY,
  output logic               ROUTE_OK
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  function automatic logic reg_hit(input logic [AW-1:0] addr,
                                   input logic [7:0]    idx);
    return addr == AW'({idx, 2'b00});
  endfunction : reg_hit

  // Reserved codes give no defined routing; flagged so the mux can idle
  function automatic logic code_defined(input logic [4:0] code);
    return (code <= `AIN_LAST_CODE) ||
           (code == `REF_POS_CODE)  ||
           (code == `REF_NEG_CODE); // R1 R10 R12
  endfunction : code_defined

  // Field pickers shared by every channel's decode
  function automatic logic [4:0] pos_field(input chmap_pkg::map_word_t w);
    return w[`MAP_POS_HI:`MAP_POS_LO];
  endfunction : pos_field

  function automatic logic [4:0] neg_field(input chmap_pkg::map_word_t w);
    return w[`MAP_NEG_HI:`MAP_NEG_LO];
  endfunction : neg_field

  function automatic logic [1:0] setup_field(input chmap_pkg::map_word_t w);
    return w[`MAP_SETUP_HI:`MAP_SETUP_LO];
  endfunction : setup_field

  // One strobe per setup, so its register set moves as a whole
  function automatic logic [3:0] setup_onehot(input logic [1:0] code);
    logic [3:0] hot;
    hot       = 4'h0;
    hot[code] = 1'b1;
    return hot;
  endfunction : setup_onehot

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------

  logic hit_first;
  logic hit_second;
  logic hit_status;
  logic hit_any;
  logic setup_phase;
  logic wr_access;

  assign hit_first   = reg_hit(PADDR, `IDX_FIRST_MAP);
  assign hit_second  = reg_hit(PADDR, `IDX_SECOND_MAP); // R2
  assign hit_status  = reg_hit(PADDR, `IDX_SEQ_STATUS);
  assign hit_any     = hit_first | hit_second | hit_status;
  assign setup_phase = PSEL & ~PENABLE;
  // Writes land only at the access edge; status and stray addresses ignore them
  assign wr_access   = PSEL & PENABLE & PWRITE;

  // Zero wait states: the response is prepared during setup
  assign PREADY = 1'b1;

  // ----------------------------------------------------------------
  // Channel map registers
  // ----------------------------------------------------------------

  logic [NCH-1:0]         wr_sel;
  chmap_pkg::map_word_t   map_q [NCH];
  logic [NCH-1:0]         ch_enable;

  generate
    for (genvar g = 0; g < NCH; g++) begin : g_sel
      // Map g sits g indexes above the first map
      assign wr_sel[g] = wr_access & reg_hit(PADDR, 8'(`IDX_FIRST_MAP + g)); // R2
    end
  endgenerate

  generate
    for (genvar g = 0; g < NCH; g++) begin : g_map
      // Both maps reset to AIN0/AIN1, setup 0, disabled
      chmap_word #(
        .RESET_VAL (`MAP_RESET)
      ) u_word (
        .clk     (CLK),
        .rst     (RST),
        .wr_lo   (wr_sel[g] & PSTRB[0]),
        .wr_hi   (wr_sel[g] & PSTRB[1]),
        .wr_data (PWDATA[15:0]),
        .q       (map_q[g])
      ); // R1 R3 R7 R10

      assign ch_enable[g] = map_q[g][`MAP_EN_BIT]; // R4
    end
  endgenerate

  // ----------------------------------------------------------------
  // Per-channel field decode
  // ----------------------------------------------------------------

  logic [4:0]     ch_pos   [NCH];
  logic [4:0]     ch_neg   [NCH];
  logic [1:0]     ch_setup [NCH];
  logic [NCH-1:0] ch_ok;
  logic [31:0]    map_rd   [NCH];

  generate
    for (genvar g = 0; g < NCH; g++) begin : g_dec
      assign ch_pos[g]   = pos_field(map_q[g]); // R10
      assign ch_neg[g]   = neg_field(map_q[g]); // R1
      assign ch_setup[g] = setup_field(map_q[g]); // R7
      // Both codes must be defined for the route to count as sound
      assign ch_ok[g]    = code_defined(ch_pos[g]) & code_defined(ch_neg[g]); // R12
      // Upper half of the bus word and reserved bits always read zero
      assign map_rd[g]   = {16'h0000, map_q[g]}; // R3 R6 R11
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------

  chmap_pkg::seq_state_t seq_state;
  logic                  seq_ch;
  logic                  seq_run;

  chan_sequencer #(
    .NCH (NCH),
    .CW  (1)
  ) u_seq (
    .clk       (CLK),
    .rst       (RST),
    .enable    (ch_enable),
    .conv_done (CONV_DONE),
    .state     (seq_state),
    .cur_ch    (seq_ch)
  ); // R5

  assign seq_run = (seq_state == chmap_pkg::SEQ_RUN);

  // ----------------------------------------------------------------
  // Converter-facing routing
  // ----------------------------------------------------------------

  // Outputs leave reset showing the fields of the reset map word
  localparam chmap_pkg::map_word_t RESET_WORD  = `MAP_RESET;
  localparam logic [4:0]           POS_RESET   = RESET_WORD[`MAP_POS_HI:`MAP_POS_LO];
  localparam logic [4:0]           NEG_RESET   = RESET_WORD[`MAP_NEG_HI:`MAP_NEG_LO];
  localparam logic [1:0]           SETUP_RESET = RESET_WORD[`MAP_SETUP_HI:`MAP_SETUP_LO];

  logic [4:0]           pos_code;
  logic [4:0]           neg_code;
  logic [1:0]           setup_code;
  logic                 route_ok_now;

  logic                 active_r;
  logic                 active_nxt;
  logic                 index_r;
  logic                 index_nxt;
  logic [4:0]           pos_r;
  logic [4:0]           pos_nxt;
  logic [4:0]           neg_r;
  logic [4:0]           neg_nxt;
  logic [1:0]           setup_r;
  logic [1:0]           setup_nxt;
  logic [3:0]           apply_r;
  logic [3:0]           apply_nxt;
  logic                 ok_r;
  logic                 ok_nxt;

  always_comb begin
    pos_code     = ch_pos[seq_ch]; // R10
    neg_code     = ch_neg[seq_ch]; // R1
    setup_code   = ch_setup[seq_ch]; // R7
    route_ok_now = ch_ok[seq_ch]; // R12

    active_nxt = seq_run;
    index_nxt  = seq_ch;
    pos_nxt    = pos_code;
    neg_nxt    = neg_code;
    setup_nxt  = setup_code;
    ok_nxt     = seq_run & route_ok_now;
    apply_nxt  = 4'h0;
    // One strobe selects the whole set of four setup registers
    if (seq_run) begin
      apply_nxt = setup_onehot(setup_code); // R8
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      active_r <= 1'b0;
      index_r  <= 1'b0;
      pos_r    <= POS_RESET;
      neg_r    <= NEG_RESET;
      setup_r  <= SETUP_RESET;
      apply_r  <= 4'h0;
      ok_r     <= 1'b0;
    end else begin
      active_r <= active_nxt;
      index_r  <= index_nxt;
      pos_r    <= pos_nxt;
      neg_r    <= neg_nxt;
      setup_r  <= setup_nxt;
      apply_r  <= apply_nxt;
      ok_r     <= ok_nxt;
    end
  end

  assign CH_ACTIVE   = active_r;
  assign CH_INDEX    = index_r;
  assign AIN_POS_SEL = pos_r;
  assign AIN_NEG_SEL = neg_r;
  assign SETUP_SEL   = setup_r;
  assign SETUP_APPLY = apply_r;
  assign ROUTE_OK    = ok_r;

  // ----------------------------------------------------------------
  // Read data and error response
  // ----------------------------------------------------------------

  logic [31:0] status_word;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        err_r;
  logic        err_nxt;

  always_comb begin
    status_word                 = 32'h0000_0000;
    status_word[`STS_RUN_BIT]   = seq_run;
    status_word[`STS_CH_BIT]    = seq_ch;
    status_word[`STS_OK_BIT]    = route_ok_now;
    status_word[`STS_SETUP_LO +: 2] = setup_code;
  end

  always_comb begin
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    if (setup_phase) begin
      rdata_nxt = 32'h0000_0000;
      // Unmapped addresses and writes to status answer with an error
      err_nxt   = ~hit_any | (PWRITE & hit_status);
      if (!PWRITE) begin
        if (hit_first) begin
          rdata_nxt = map_rd[0]; // R6 R11
        end else if (hit_second) begin
          rdata_nxt = map_rd[1]; // R6 R11
        end else if (hit_status) begin
          rdata_nxt = status_word;
        end
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_r <= 32'h0000_0000;
      err_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
    end
  end

  assign PRDATA  = rdata_r;
  assign PSLVERR = err_r & PSEL & PENABLE;

endmodule : chmap_bank
`default_nettype wire

//--- tb/chmap_bank_chk.sv
// Port checker for the channel map bank
`default_nettype none
module chmap_bank_chk #(
  parameter int NCH = 2,
  parameter int AW  = 8
) (
  input wire logic          CLK,
  input wire logic          RST,
  input wire logic          PSEL,
  input wire logic          PENABLE,
  input wire logic          PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic [31:0]   PWDATA,
  input wire logic [3:0]    PSTRB,
  input wire logic [31:0]   PRDATA,
  input wire logic          PREADY,
  input wire logic          PSLVERR,
  input wire logic          CONV_DONE,
  input wire logic          CH_ACTIVE,
  input wire logic          CH_INDEX,
  input wire logic [4:0]    AIN_POS_SEL,
  input wire logic [4:0]    AIN_NEG_SEL,
  input wire logic [1:0]    SETUP_SEL,
  input wire logic [3:0]    SETUP_APPLY,
  input wire logic          ROUTE_OK
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  wire logic acc = PSEL && PENABLE;
  wire logic hit = PADDR == 8'h44 || PADDR == 8'h48;
  wire logic rd  = acc && !PWRITE && hit;

  function automatic logic defd(input logic [4:0] c);
    return c <= 5'h04 || c == 5'h15 || c == 5'h16;
  endfunction : defd

  sequence en2_wr_s;
    acc && PWRITE && PADDR == 8'h48 && PSTRB[1] && PWDATA[15];
  endsequence
  // Sequencer start plus output register stage
  sequence runs_s;
    ##[1:3] CH_ACTIVE;
  endsequence

  chk_upper_zero: assert property (rd |-> PRDATA[31:16] == 16'h0000) else $error("upper half set");
  chk_rsv_bit: assert property (rd |-> !PRDATA[14]) else $error("bit 14 set");
  chk_rsv_pair: assert property (rd |-> PRDATA[11:10] == 2'b00) else $error("bits 11:10 set");
  chk_enable_start: assert property (en2_wr_s |-> runs_s) else $error("no start");
  chk_apply_match: assert property (CH_ACTIVE |-> SETUP_APPLY == 4'h1 << SETUP_SEL) else $error("bad apply");
  chk_idle_quiet: assert property (!CH_ACTIVE |-> SETUP_APPLY == 4'h0 && !ROUTE_OK) else $error("idle drive");
  chk_route_flag: assert property (CH_ACTIVE |-> ROUTE_OK == (defd(AIN_POS_SEL) && defd(AIN_NEG_SEL)))
    else $error("route flag");
  chk_unmapped_err: assert property (acc && !hit && PADDR != 8'h4C |-> PSLVERR) else $error("no error");
  chk_err_phase: assert property (PSLVERR |-> acc && !hit) else $error("stray error");
endmodule : chmap_bank_chk
`default_nettype wire

//--- tb/chmap_bank_test.sv
// Self-checking bench for the channel map bank
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; $display("BAD %0t %h %h", $time, g, e); end end
module chmap_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [3:0]  PSTRB = 4'h0;
  logic        CONV_DONE = 1'b0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, CH_ACTIVE, CH_INDEX, ROUTE_OK;
  logic [4:0]  AIN_POS_SEL, AIN_NEG_SEL;
  logic [1:0]  SETUP_SEL;
  logic [3:0]  SETUP_APPLY;
  logic [31:0] rd_q;
  logic        err_q;
  int          err_total = 0;
  int          checks_done = 0;
  logic [4:0]  codes [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h15, 5'h16};

  always #4 CLK = ~CLK;

  chmap_bank dut_u (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CONV_DONE(CONV_DONE), .CH_ACTIVE(CH_ACTIVE), .CH_INDEX(CH_INDEX), .AIN_POS_SEL(AIN_POS_SEL),
    .AIN_NEG_SEL(AIN_NEG_SEL), .SETUP_SEL(SETUP_SEL), .SETUP_APPLY(SETUP_APPLY), .ROUTE_OK(ROUTE_OK)
  );

  // ----------------
  // Bus and helpers
  // ----------------
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask : tick

  // Idle cycle after each transfer keeps requests apart
  task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= {16'h0000, d};
    PSTRB  <= s;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 64);
    rd_q = PRDATA;
    err_q = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : xfer

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 16'h0000, 4'h0);
    `CHK({err_q, rd_q}, {1'b0, e})
  endtask : rd_chk

  task automatic pulse();
    @(posedge CLK);
    CONV_DONE <= 1'b1;
    @(posedge CLK);
    CONV_DONE <= 1'b0;
    tick(2);
  endtask : pulse

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // ----------------
  // Tests
  // ----------------
  initial begin
    tick(5);
    RST <= 1'b0;
    `CHK({CH_ACTIVE, AIN_POS_SEL, AIN_NEG_SEL, SETUP_APPLY}, {1'b0, 5'h00, 5'h01, 4'h0})
    rd_chk(8'h44, 32'h0001);
    rd_chk(8'h48, 32'h0001);
    for (int i = 0; i < 7; i++) begin
      xfer(8'h44, 1'b1, 16'h0000, 4'h3);
      xfer(8'h44, 1'b1, {2'b10, i[1:0], 2'b00, codes[6-i], codes[i]}, 4'h3);
      tick(3);
      `CHK({CH_ACTIVE, PREADY}, 2'b11)
      `CHK({AIN_POS_SEL, AIN_NEG_SEL, SETUP_APPLY}, {codes[6-i], codes[i], 4'h1 << i[1:0]})
      `CHK({CH_INDEX, SETUP_SEL, ROUTE_OK}, {1'b0, i[1:0], 1'b1})
      rd_chk(8'h44, {16'h0000, 2'b10, i[1:0], 2'b00, codes[6-i], codes[i]});
    end
    xfer(8'h48, 1'b1, 16'hFFFF, 4'h3);
    rd_chk(8'h48, 32'h0000B3FF);
    pulse();
    `CHK({CH_INDEX, SETUP_SEL, ROUTE_OK}, {1'b1, 2'b11, 1'b0})
    pulse();
    `CHK({CH_INDEX, SETUP_SEL}, {1'b0, 2'b10})
    xfer(8'h48, 1'b1, 16'h7FFF, 4'h2);
    pulse();
    `CHK(CH_INDEX, 1'b0)
    rd_chk(8'h48, 32'h000033FF);
    xfer(8'h48, 1'b1, 16'h8000, 4'h1);
    rd_chk(8'h48, 32'h00003300);
    rd_chk(8'h4C, 32'h00000025);
    xfer(8'h50, 1'b0, 16'h0000, 4'h0);
    `CHK({err_q, rd_q}, {1'b1, 32'h0})
    xfer(8'h4C, 1'b1, 16'hFFFF, 4'h3);
    `CHK(err_q, 1'b1)
    xfer(8'h48, 1'b1, 16'hA000, 4'h3);
    pulse();
    `CHK({CH_INDEX, SETUP_SEL, SETUP_APPLY, ROUTE_OK}, {1'b1, 2'b10, 4'h4, 1'b1})
    RST <= 1'b1;
    tick(2);
    `CHK({CH_ACTIVE, SETUP_APPLY}, {1'b0, 4'h0})
    RST <= 1'b0;
    rd_chk(8'h44, 32'h0001);
    rd_chk(8'h48, 32'h0001);
    wrap_up();
  end

  // Bounded far above the roughly 150 cycles the tests need
  initial begin
    repeat (5000) @(posedge CLK);
    err_total++;
    wrap_up();
  end
endmodule : chmap_bank_test

bind chmap_bank chmap_bank_chk #(.NCH(NCH), .AW(AW)) chk_u (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CONV_DONE(CONV_DONE), .CH_ACTIVE(CH_ACTIVE), .CH_INDEX(CH_INDEX), .AIN_POS_SEL(AIN_POS_SEL),
  .AIN_NEG_SEL(AIN_NEG_SEL), .SETUP_SEL(SETUP_SEL), .SETUP_APPLY(SETUP_APPLY), .ROUTE_OK(ROUTE_OK)
);
`default_nettype wire
